// ===== servo_seq_cfg.svh
`ifndef SERVO_SEQ_CFG_SVH
`define SERVO_SEQ_CFG_SVH
// Register word offsets (byte addresses)
`define ADR_INPOS 8'h00
`define ADR_ZSPD 8'h04
`define ADR_OVFL 8'h08
`define ADR_OVDIS 8'h0c
`define ADR_PSTOP 8'h10
`define ADR_ASTOP 8'h14
`define ADR_SOFF 8'h18
`define ADR_BRK 8'h1c
`define ADR_WSEL 8'h20
`define ADR_ROT 8'h24
`define ADR_STAT 8'h28
`define ADR_IRQ 8'h2c
`define ADR_MASK 8'h30
`define ADR_LOAD 8'h34
// Reset values
`define RST_INPOS 16'h0019
`define RST_ZSPD 16'h0014
`define RST_OVFL 16'h0064
`define RST_ROT 16'h0032
`define RST_BRK 7'h0a
// Speed hysteresis in r/min
`define HYST_RPM 16'h000a
// Encoder lines and quadrature factor
`define ENC_LINES 2500
`define ENC_MULT 4
// Overflow unit is 256 pulses
`define OVF_SHIFT 8
// Brake time unit in ms and clock rate in kHz
`define BRK_UNIT_MS 2
`define CLK_KHZ 10000
`define BRK_TICK_CYC (`BRK_UNIT_MS * `CLK_KHZ)
// Interrupt bits
`define IRQ_OVF 0
`define IRQ_INP 1
`define IRQ_SOFF 2
`define IRQ_W 3
`endif

// ===== servo_seq_pkg.sv
package servo_seq_pkg;
    typedef enum logic [3:0]
    {
        ST_RUN = 4'b0001,
        ST_DECEL = 4'b0010,
        ST_BRAKE = 4'b0100,
        ST_OFF = 4'b1000
    } seq_state_e;
endpackage : servo_seq_pkg

// ===== servo_sequence_supervisor.sv
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "servo_seq_cfg.svh"

module servo_sequence_supervisor
    import servo_seq_pkg::*;
(
    input wire logic clk_i, // 10 MHz clock
    input wire logic rst_i, // Sync reset, high
    input wire logic ce_i, // Clock enable
    input wire logic [7:0] adr_i, // Wishbone address
    input wire logic [31:0] dat_i, // Write data
    output logic [31:0] dat_o, // Read data
    input wire logic we_i, // Write enable
    input wire logic [3:0] sel_i, // Byte selects
    input wire logic cyc_i, // Cycle
    input wire logic stb_i, // Strobe
    output logic ack_o, // Acknowledge
    output logic irq_o, // Interrupt level
    input wire logic cmd_up_i, // Command pulse up
    input wire logic cmd_dn_i, // Command pulse down
    input wire logic enc_a_i, // Encoder phase A
    input wire logic enc_b_i, // Encoder phase B
    input wire logic signed [15:0] speed_i, // Motor speed r/min
    input wire logic run_i, // Run command
    input wire logic fwd_prohibit_in, // Forward prohibit
    input wire logic rev_prohibit_i, // Reverse prohibit
    input wire logic ext_alarm_i, // Other alarm source
    input wire logic speed_mode_i, // 1: internal speed mode
    output logic positioning_done_out, // Positioning done
    output logic rotation_detect_out, // Rotation detect
    output logic warn_o, // Warning output
    output logic brake_interlock_out, // Brake release
    output logic servo_on_o, // Power stage on
    output logic dyn_brake_o, // Dynamic brake on
    output logic fwd_torque_en_o, // Forward torque allowed
    output logic rev_torque_en_o, // Reverse torque allowed
    output logic zero_speed_cmd_o, // Zero speed designation
    output logic servo_lock_o, // Position hold
    output logic alarm_o // Alarm active
);

    // ************************************************
    // Register storage
    // ************************************************
    logic [15:0] in_position_range_q, zero_speed_threshold_q, deviation_overflow_level_q;
    logic [15:0] rot_threshold_q;
    logic overflow_alarm_disable_q;
    logic [1:0] prohibit_stop_select_q, alarm_stop_select_q;
    logic [2:0] servo_off_stop_select_q;
    logic [6:0] stopped_brake_delay_q;
    logic warning_output_select_q;
    // Active copies, loaded only at power-up load
    logic [15:0] a_inpos_q, a_zspd_q, a_ovfl_q, a_rot_q;
    logic a_ovdis_q, a_wsel_q;
    logic [1:0] a_pstop_q, a_astop_q;
    logic [2:0] a_soff_q;
    logic [6:0] a_brk_q;
    logic loaded_q;
    logic [3:0] irq_stat_q, irq_mask_q;
    logic signed [31:0] dev_q;
    logic [31:0] dev_abs;
    logic ovf_alarm_q, zero_q, inp_ev;
    logic [15:0] spd_abs;
    seq_state_e st_q;
    logic wr, rd_hit, load_wr;
    logic [31:0] rd_d;

    // Writes land at the edge where the master samples ack high
    assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign load_wr = wr & (adr_i == `ADR_LOAD) & dat_i[0];

    // Wishbone ack, one cycle per request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else if (ce_i)
            ack_o <= cyc_i & stb_i & ~ack_o;
    end

    // Setting registers writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_position_range_q <= `RST_INPOS;
            zero_speed_threshold_q <= `RST_ZSPD;
            deviation_overflow_level_q <= `RST_OVFL;
            rot_threshold_q <= `RST_ROT;
            overflow_alarm_disable_q <= 1'b0;
            prohibit_stop_select_q <= 2'h0;
            alarm_stop_select_q <= 2'h0;
            servo_off_stop_select_q <= 3'h0;
            stopped_brake_delay_q <= `RST_BRK;
            warning_output_select_q <= 1'b0;
        end
        else if (ce_i && wr)
        begin
            case (adr_i)
                `ADR_INPOS: in_position_range_q <= {1'b0, dat_i[14:0]};
                `ADR_ZSPD: zero_speed_threshold_q <= dat_i[15:0];
                `ADR_OVFL: deviation_overflow_level_q <= {1'b0, dat_i[14:0]};
                `ADR_ROT: rot_threshold_q <= dat_i[15:0];
                `ADR_OVDIS: overflow_alarm_disable_q <= dat_i[0];
                `ADR_PSTOP: prohibit_stop_select_q <= (dat_i[1:0] == 2'h3) ? 2'h2 : dat_i[1:0];
                `ADR_ASTOP: alarm_stop_select_q <= dat_i[1:0];
                `ADR_SOFF: servo_off_stop_select_q <= dat_i[2:0];
                `ADR_BRK: stopped_brake_delay_q <= dat_i[6:0];
                `ADR_WSEL: warning_output_select_q <= dat_i[0];
                default: ;
            endcase
        end
    end

    // Active settings take effect only at reset and at the first load after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            a_inpos_q <= `RST_INPOS;
            a_zspd_q <= `RST_ZSPD;
            a_ovfl_q <= `RST_OVFL;
            a_rot_q <= `RST_ROT;
            a_ovdis_q <= 1'b0;
            a_wsel_q <= 1'b0;
            a_pstop_q <= 2'h0;
            a_astop_q <= 2'h0;
            a_soff_q <= 3'h0;
            a_brk_q <= `RST_BRK;
            loaded_q <= 1'b0;
        end
        else if (ce_i && load_wr && !loaded_q)
        begin
            a_inpos_q <= in_position_range_q;
            a_zspd_q <= zero_speed_threshold_q;
            a_ovfl_q <= deviation_overflow_level_q;
            a_rot_q <= rot_threshold_q;
            a_ovdis_q <= overflow_alarm_disable_q;
            a_wsel_q <= warning_output_select_q;
            a_pstop_q <= prohibit_stop_select_q;
            a_astop_q <= alarm_stop_select_q;
            a_soff_q <= servo_off_stop_select_q;
            a_brk_q <= stopped_brake_delay_q;
            loaded_q <= 1'b1;
        end
    end

    // ************************************************
    // Deviation counter
    // ************************************************
    logic [1:0] enc_q;
    logic enc_step, enc_dir, dev_clr;
    // Every edge of A or B is one count, four per line
    assign enc_step = (enc_q[0] ^ enc_a_i) | (enc_q[1] ^ enc_b_i);
    assign enc_dir = enc_q[0] ^ enc_b_i;
    assign dev_clr = alarm_o
        | ((st_q != ST_RUN) && !a_soff_q[2]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            enc_q <= {enc_b_i, enc_a_i}; // Follows pins, no false edge after reset
        else if (ce_i)
            enc_q <= {enc_b_i, enc_a_i};
    end

    // Commands add, feedback subtracts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dev_q <= 32'sh0;
        else if (ce_i)
        begin
            if (dev_clr)
                dev_q <= 32'sh0;
            else
                dev_q <= dev_q + {{31{cmd_dn_i & ~cmd_up_i}}, cmd_up_i ^ cmd_dn_i}
                    - {{31{enc_step & ~enc_dir}}, enc_step};
        end
    end

    assign dev_abs = dev_q[31] ? 32'(-dev_q) : 32'(dev_q);
    assign spd_abs = speed_i[15] ? 16'(-speed_i) : 16'(speed_i);

    // ************************************************
    // Detection outputs
    // ************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            positioning_done_out <= 1'b0;
        else if (ce_i)
            positioning_done_out <= dev_abs < {16'h0, a_inpos_q};
    end

    // Zero speed with hysteresis band
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            zero_q <= 1'b1;
        else if (ce_i)
        begin
            if (spd_abs < a_zspd_q)
                zero_q <= 1'b1;
            else if ({1'b0, spd_abs} >= {1'b0, a_zspd_q} + {1'b0, `HYST_RPM})
                zero_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            warn_o <= 1'b0;
        else if (ce_i)
            warn_o <= a_wsel_q & zero_q;
    end

    // Rotation detect, only in speed mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rotation_detect_out <= 1'b0;
        else if (ce_i)
        begin
            if (!speed_mode_i)
                rotation_detect_out <= 1'b0;
            else if (spd_abs > a_rot_q)
                rotation_detect_out <= 1'b1;
            else if ({1'b0, spd_abs} + {1'b0, `HYST_RPM} <= {1'b0, a_rot_q})
                rotation_detect_out <= 1'b0;
        end
    end

    // Overflow alarm, latched until reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ovf_alarm_q <= 1'b0;
        else if (ce_i && !a_ovdis_q)
        begin
            if (dev_abs > ({16'h0, a_ovfl_q} << `OVF_SHIFT))
                ovf_alarm_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            alarm_o <= 1'b0;
        else if (ce_i)
            alarm_o <= (ovf_alarm_q & ~a_ovdis_q) | ext_alarm_i;
    end

    // ************************************************
    // Stop sequence
    // ************************************************
    logic [1:0] stop_sel;
    logic [15:0] tick_q;
    logic [6:0] brk_cnt_q;
    // Alarm wins over servo-off
    assign stop_sel = alarm_o ? a_astop_q : a_soff_q[1:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_RUN;
            tick_q <= 16'h0;
            brk_cnt_q <= 7'h0;
        end
        else if (ce_i)
        begin
            case (st_q)
                ST_RUN:
                begin
                    tick_q <= 16'h0;
                    brk_cnt_q <= 7'h0;
                    if (alarm_o || (!run_i && !zero_q))
                        st_q <= ST_DECEL;
                    else if (!run_i)
                        st_q <= ST_BRAKE;
                end
                ST_DECEL:
                    if (zero_q)
                        st_q <= ST_OFF;
                ST_BRAKE:
                begin
                    if (brk_cnt_q >= a_brk_q)
                        st_q <= ST_OFF;
                    else if (tick_q == 16'(`BRK_TICK_CYC - 1))
                    begin
                        tick_q <= 16'h0;
                        brk_cnt_q <= brk_cnt_q + 7'h1;
                    end
                    else
                        tick_q <= tick_q + 16'h1;
                end
                ST_OFF:
                    if (run_i && !alarm_o)
                        st_q <= ST_RUN;
                default: st_q <= ST_RUN;
            endcase
        end
    end

    // Power stage and brake outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            servo_on_o <= 1'b0;
            dyn_brake_o <= 1'b0;
            brake_interlock_out <= 1'b0;
        end
        else if (ce_i)
        begin
            servo_on_o <= (st_q == ST_RUN) | (st_q == ST_BRAKE);
            brake_interlock_out <= (st_q == ST_RUN) && run_i;
            case (st_q)
                ST_DECEL: dyn_brake_o <= ~stop_sel[0];
                ST_OFF: dyn_brake_o <= ~stop_sel[1];
                ST_RUN: dyn_brake_o <= (fwd_prohibit_in | rev_prohibit_i)
                    && a_pstop_q == 2'h0;
                default: dyn_brake_o <= 1'b0;
            endcase
        end
    end

    // Drive prohibit handling
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fwd_torque_en_o <= 1'b0;
            rev_torque_en_o <= 1'b0;
            zero_speed_cmd_o <= 1'b0;
            servo_lock_o <= 1'b0;
        end
        else if (ce_i)
        begin
            fwd_torque_en_o <= (st_q == ST_RUN) && !(fwd_prohibit_in && a_pstop_q != 2'h2);
            rev_torque_en_o <= (st_q == ST_RUN) && !(rev_prohibit_i && a_pstop_q != 2'h2);
            zero_speed_cmd_o <= (fwd_prohibit_in | rev_prohibit_i) && a_pstop_q == 2'h2
                && speed_mode_i;
            servo_lock_o <= (fwd_prohibit_in | rev_prohibit_i) && a_pstop_q == 2'h2
                && !speed_mode_i;
        end
    end

    // ************************************************
    // Interrupts and read back
    // ************************************************
    assign inp_ev = dev_abs < {16'h0, a_inpos_q} && !positioning_done_out;

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat_q <= 4'h0;
        else if (ce_i)
            irq_stat_q <= (irq_stat_q
                & ~((wr && adr_i == `ADR_IRQ) ? {1'b0, dat_i[`IRQ_W-1:0]} : 4'h0))
                | {1'b0, st_q == ST_OFF && servo_on_o, inp_ev, ovf_alarm_q};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask_q <= 4'h0;
        else if (ce_i && wr && adr_i == `ADR_MASK)
            irq_mask_q <= dat_i[3:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else if (ce_i)
            irq_o <= |(irq_stat_q & irq_mask_q);
    end

    // Read mux
    always_comb
    begin
        rd_d = 32'h0;
        case (adr_i)
            `ADR_INPOS: rd_d = {16'h0, in_position_range_q};
            `ADR_ZSPD: rd_d = {16'h0, zero_speed_threshold_q};
            `ADR_OVFL: rd_d = {16'h0, deviation_overflow_level_q};
            `ADR_ROT: rd_d = {16'h0, rot_threshold_q};
            `ADR_OVDIS: rd_d = {31'h0, overflow_alarm_disable_q};
            `ADR_PSTOP: rd_d = {30'h0, prohibit_stop_select_q};
            `ADR_ASTOP: rd_d = {30'h0, alarm_stop_select_q};
            `ADR_SOFF: rd_d = {29'h0, servo_off_stop_select_q};
            `ADR_BRK: rd_d = {25'h0, stopped_brake_delay_q};
            `ADR_WSEL: rd_d = {31'h0, warning_output_select_q};
            `ADR_STAT: rd_d = {st_q, 20'h0, loaded_q, alarm_o, zero_q, positioning_done_out,
                dev_abs[3:0]};
            `ADR_IRQ: rd_d = {28'h0, irq_stat_q};
            `ADR_MASK: rd_d = {28'h0, irq_mask_q};
            `ADR_LOAD: rd_d = {31'h0, loaded_q};
            default: rd_d = 32'h0;
        endcase
    end
    assign rd_hit = cyc_i & stb_i & ~ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0;
        else if (ce_i && rd_hit)
            dat_o <= rd_d;
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_ovf;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !a_ovdis_q && dev_abs > ({16'h0, a_ovfl_q} << `OVF_SHIFT) |=> ovf_alarm_q;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow alarm missed");

    property p_ovdis;
        @(posedge clk_i) disable iff (rst_i)
        a_ovdis_q && !ext_alarm_i && ce_i |=> !alarm_o;
    endproperty
    a_ovdis: assert property (p_ovdis) else $error("disabled alarm raised");

    property p_inp;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> positioning_done_out == ($past(dev_abs) < {16'h0, $past(a_inpos_q)});
    endproperty
    a_inp: assert property (p_inp) else $error("done output wrong");

    property p_warn;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !a_wsel_q |=> !warn_o;
    endproperty
    a_warn: assert property (p_warn) else $error("warning without select");

    property p_zero;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && spd_abs < a_zspd_q |=> zero_q;
    endproperty
    a_zero: assert property (p_zero) else $error("zero speed missed");

    property p_rot;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && speed_mode_i && spd_abs > a_rot_q |=> rotation_detect_out;
    endproperty
    a_rot: assert property (p_rot) else $error("rotation missed");

    property p_clr;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && alarm_o |=> dev_q == 32'sh0;
    endproperty
    a_clr: assert property (p_clr) else $error("deviation not cleared");

    property p_brk;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && st_q == ST_BRAKE |=> !brake_interlock_out;
    endproperty
    a_brk: assert property (p_brk) else $error("brake not applied");

endmodule : servo_sequence_supervisor
`default_nettype wire

// ===== servo_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Motor with encoder and brake
// ********************************
module servo_motor_model #(
    parameter int BRAKE_LAG_CYC = 1000
) (
    input wire logic clk_i, // Clock
    input wire logic step_i, // One encoder edge forward
    input wire logic brake_release_i, // Brake release
    output logic enc_a_o, // Phase A
    output logic enc_b_o, // Phase B
    output logic brake_held_o // Brake gripping
);
    logic [1:0] ph_q = 2'h0;
    int lag_q = 0;

    // Gray sequence, four edges per line
    always_ff @(posedge clk_i)
    begin
        if (step_i)
            ph_q <= ph_q + 2'h1;
    end
    assign enc_a_o = ph_q[1];
    assign enc_b_o = ph_q[1] ^ ph_q[0];

    // Brake grips only after its mechanical lag
    always_ff @(posedge clk_i)
    begin
        if (brake_release_i)
            lag_q <= 0;
        else if (lag_q < BRAKE_LAG_CYC)
            lag_q <= lag_q + 1;
    end
    assign brake_held_o = (lag_q >= BRAKE_LAG_CYC);
endmodule : servo_motor_model
`default_nettype wire

// ===== tb_servo_sequence_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "servo_seq_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_servo_sequence_supervisor
    import servo_seq_pkg::*;
;
    // ********************************
    // Stimulus, bus tasks and checks
    // ********************************
    typedef struct packed {logic signed [15:0] s; logic w; logic r;} row_s;
    row_s rows [8] = '{'{16'sh0000, 1'b1, 1'b0}, '{16'sh0019, 1'b1, 1'b0},
        '{16'sh0064, 1'b0, 1'b1}, '{16'sh002d, 1'b0, 1'b1},
        '{16'shff9c, 1'b0, 1'b1}, '{16'sh0005, 1'b1, 1'b0},
        '{16'shfffb, 1'b1, 1'b0}, '{16'sh03e8, 1'b0, 1'b1}};
    logic [31:0] rv [9] = '{32'h19, 32'h14, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'ha, 32'h32};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0, up = 1'b0, dn = 1'b0, step = 1'b0;
    logic run = 1'b0, fp = 1'b0, rp = 1'b0, ext = 1'b0, mode = 1'b0;
    logic signed [15:0] spd = 16'sh0000;
    logic ack, irq, enc_a, enc_b, done, rot, warn, bki, son, dyn;
    logic fte, rte, zcmd, lock, alm, held;
    int n_mismatch = 0;
    int samples_checked = 0;

    // Clock of 100 ns period
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    servo_sequence_supervisor i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(4'hf), .cyc_i(cyc),
        .stb_i(stb), .ack_o(ack), .irq_o(irq), .cmd_up_i(up), .cmd_dn_i(dn),
        .enc_a_i(enc_a), .enc_b_i(enc_b), .speed_i(spd), .run_i(run),
        .fwd_prohibit_in(fp), .rev_prohibit_i(rp), .ext_alarm_i(ext), .speed_mode_i(mode),
        .positioning_done_out(done), .rotation_detect_out(rot), .warn_o(warn),
        .brake_interlock_out(bki), .servo_on_o(son), .dyn_brake_o(dyn),
        .fwd_torque_en_o(fte), .rev_torque_en_o(rte), .zero_speed_cmd_o(zcmd),
        .servo_lock_o(lock), .alarm_o(alm));

    servo_motor_model i_motor (.clk_i(clk_i), .step_i(step), .brake_release_i(bki),
        .enc_a_o(enc_a), .enc_b_o(enc_b), .brake_held_o(held));

    task automatic complete_run;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        `CHK(n < 50, 1'b1)
        @(posedge clk_i);
    endtask : wb

    task automatic settle;
        repeat (8) @(posedge clk_i);
    endtask : settle

    task automatic pulse(input logic u, input logic d, input logic s, input int n);
        repeat (n)
        begin
            up <= u;
            dn <= d;
            step <= s;
            @(posedge clk_i);
            up <= 1'b0;
            dn <= 1'b0;
            step <= 1'b0;
            @(posedge clk_i);
        end
    endtask : pulse

    // Fresh power-up, settings written and latched; brake delay 2 ms over lag
    task automatic cfg(input logic [1:0] ps, input logic [1:0] as, input logic [2:0] so,
        input logic od);
        rst_i <= 1'b1;
        ext <= 1'b0;
        fp <= 1'b0;
        rp <= 1'b0;
        spd <= 16'sh0000;
        run <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(`ADR_INPOS, 1'b1, 32'h5);
        wb(`ADR_OVFL, 1'b1, 32'h1);
        wb(`ADR_OVDIS, 1'b1, {31'h0, od});
        wb(`ADR_PSTOP, 1'b1, {30'h0, ps});
        wb(`ADR_ASTOP, 1'b1, {30'h0, as});
        wb(`ADR_SOFF, 1'b1, {29'h0, so});
        wb(`ADR_BRK, 1'b1, 32'h1);
        wb(`ADR_WSEL, 1'b1, {31'h0, ~od});
        wb(`ADR_MASK, 1'b1, 32'h7);
        wb(`ADR_LOAD, 1'b1, 32'h1);
        settle();
    endtask : cfg

    // Watchdog on a hung run
    initial
    begin
        repeat (80000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        `CHK({ack, son, alm, bki, done}, 5'h00)
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++)
        begin
            wb((i == 8) ? `ADR_ROT : 8'(i * 4), 1'b0, 32'h0);
            `CHK(q, rv[i])
        end
        wb(8'h3c, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        cfg(2'h0, 2'h0, 3'h0, 1'b0);
        mode <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            spd <= rows[i].s;
            settle();
            `CHK(warn, rows[i].w)
            `CHK(rot, rows[i].r)
        end
        wb(`ADR_WSEL, 1'b1, 32'h0);
        wb(`ADR_LOAD, 1'b1, 32'h1);
        spd <= 16'sh0000;
        mode <= 1'b0;
        settle();
        `CHK(warn, 1'b1)
        pulse(1'b0, 1'b0, 1'b1, 4);
        settle();
        `CHK(done, 1'b1)
        pulse(1'b0, 1'b0, 1'b1, 4);
        settle();
        `CHK(done, 1'b0)
        // Overflow just past 256 pulses, reverse following
        cfg(2'h0, 2'h0, 3'h0, 1'b0);
        pulse(1'b0, 1'b1, 1'b0, 256);
        settle();
        `CHK(alm, 1'b0)
        pulse(1'b0, 1'b1, 1'b0, 1);
        settle();
        `CHK(alm, 1'b1)
        wb(`ADR_STAT, 1'b0, 32'h0);
        `CHK(q[3:0], 4'h0)
        wb(`ADR_IRQ, 1'b0, 32'h0);
        `CHK(q[0], 1'b1)
        `CHK(irq, 1'b1)
        wb(`ADR_MASK, 1'b1, 32'h0);
        settle();
        `CHK(irq, 1'b0)
        cfg(2'h0, 2'h0, 3'h0, 1'b1);
        pulse(1'b1, 1'b0, 1'b0, 300);
        settle();
        `CHK(alm, 1'b0)
        `CHK(warn, 1'b0)
        // Alarm stop for every selection
        for (int i = 0; i < 4; i++)
        begin
            cfg(2'h0, i[1:0], 3'h0, 1'b0);
            pulse(1'b0, 1'b0, 1'b1, 8);
            spd <= 16'sh01f4;
            ext <= 1'b1;
            settle();
            `CHK(dyn, !i[0])
            wb(`ADR_STAT, 1'b0, 32'h0);
            `CHK(q[3:0], 4'h0)
            spd <= 16'sh0000;
            settle();
            `CHK(dyn, !i[1])
        end
        // Servo off for every selection, deviation held or cleared
        for (int i = 0; i < 8; i++)
        begin
            cfg(2'h0, 2'h0, i[2:0], 1'b0);
            pulse(1'b0, 1'b0, 1'b1, 8);
            spd <= 16'sh01f4;
            settle();
            run <= 1'b0;
            settle();
            `CHK(dyn, !i[0])
            spd <= 16'sh0000;
            settle();
            `CHK(dyn, !i[1])
            wb(`ADR_STAT, 1'b0, 32'h0);
            `CHK(q[3:0], i[2] ? 4'h8 : 4'h0)
        end
        // Stopped run-off: brake first, servo off after 20000 cycles
        cfg(2'h0, 2'h0, 3'h0, 1'b0);
        `CHK(bki, 1'b1)
        run <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(bki, 1'b0)
        repeat (19976) @(posedge clk_i);
        `CHK(son, 1'b1)
        `CHK(held, 1'b1)
        repeat (40) @(posedge clk_i);
        `CHK(son, 1'b0)
        wb(`ADR_IRQ, 1'b0, 32'h0);
        `CHK(q[2], 1'b1)
        wb(`ADR_IRQ, 1'b1, 32'h4);
        wb(`ADR_IRQ, 1'b0, 32'h0);
        `CHK(q[2], 1'b0)
        // Drive prohibit selections and modes
        for (int k = 0; k < 4; k++)
        begin
            cfg((k > 1) ? 2'h2 : k[1:0], 2'h0, 3'h0, 1'b0);
            mode <= (k == 3);
            spd <= 16'sh01f4;
            fp <= (k != 1);
            rp <= (k == 1);
            settle();
            if (k < 2)
            begin
                `CHK(fte, k == 1)
                `CHK(rte, k != 1)
                `CHK(dyn, k == 0)
            end
            else
            begin
                `CHK(lock, k == 2)
                `CHK(zcmd, k == 3)
            end
        end
        complete_run();
    end
endmodule : tb_servo_sequence_supervisor
`default_nettype wire
